// ---- src/actuator_pdo_pkg.sv ----
package actuator_pdo_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int OVERCUR_TIME_NS = 8000000;
  // Trip needs current above limit for more than this, so round up
  localparam int OVERCUR_CYCLES =
    (OVERCUR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FB_PERIOD_NS = 10000000;
  localparam int FB_PERIOD_CYCLES = FB_PERIOD_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Identifiers and object indices
  localparam logic [10:0] RPDO_BASE_ID = 11'h200;
  localparam logic [10:0] TPDO_BASE_ID = 11'h180;
  localparam logic [6:0] DEFAULT_NODE_ID = 7'h13;
  localparam logic [15:0] OBJ_MOTION_CONTROL_BITS = 16'h2104;
  localparam logic [15:0] OBJ_MEASURED_POSITION = 16'h2200;
  localparam logic [15:0] OBJ_MEASURED_CURRENT = 16'h2201;
  localparam logic [15:0] OBJ_MEASURED_DUTY_CYCLE = 16'h2202;
  localparam logic [15:0] OBJ_MOTION_DIRECTION_FLAGS = 16'h2203;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions (bit offset of the low byte in the 8-byte payload; ENABLE_BIT, EXTEND_BIT, RETRACT_BIT index a bit within one byte)
  localparam int CTL_POS_LO = 0;
  localparam int CTL_CUR_LO = 16;
  localparam int CTL_SPD_LO = 32;
  localparam int CTL_PROF_LO = 48;
  localparam int CTL_BITS_LO = 56;
  localparam int ENABLE_BIT = 0;
  localparam int EXTEND_BIT = 0;
  localparam int RETRACT_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Value ranges and reset values
  localparam logic [15:0] SPEED_MIN = 16'h00c8;
  localparam logic [15:0] SPEED_MAX = 16'h03e8;
  localparam logic [7:0] PROFILE_NORMAL = 8'h00;
  localparam logic [7:0] PROFILE_PRECISE = 8'h01;
  localparam logic [7:0] PROFILE_SMALL_STEP = 8'h02;
  localparam logic [15:0] RST_TARGET_POS = 16'h0000;
  localparam logic [15:0] RST_CURRENT_LIMIT = 16'h0000;
  localparam logic [7:0] RST_CONTROL_BITS = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [10:0] id;
    logic [63:0] data;
  } can_frame_t;

  typedef struct packed {
    logic [7:0] control_bits;
    logic [7:0] profile;
    logic [15:0] speed;
    logic [15:0] current_limit;
    logic [15:0] target_pos;
  } motion_cmd_t;

  typedef struct packed {
    logic [15:0] position;
    logic [15:0] current;
    logic [15:0] duty;
    logic extending;
    logic retracting;
    logic [7:0] error_flags;
  } sense_t;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_WAIT = 1'b1
  } tx_state_t;

endpackage

// ---- src/overcurrent_monitor.sv ----
`timescale 1ns/1ps
module overcurrent_monitor
  import actuator_pdo_pkg::*;
#(
  parameter int LIMIT_CYC = OVERCUR_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic over_limit,
  output logic trip
);

  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic trip_ff;
  logic nxt_trip;

  assign trip = trip_ff;

  // Over-limit run length; trips once the run is longer than the window
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_trip = 1'b0;
    if (!over_limit) begin
      nxt_cnt = 32'h0000_0000;
    end else if (cnt_ff == 32'(LIMIT_CYC)) begin
      nxt_trip = 1'b1;
      nxt_cnt = 32'h0000_0000;
    end else begin
      nxt_cnt = cnt_ff + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_ff <= 32'h0000_0000;
      trip_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      trip_ff <= nxt_trip;
    end
  end

endmodule

// ---- src/actuator_pdo_control_feedback.sv ----
`timescale 1ns/1ps
module actuator_pdo_control_feedback
  import actuator_pdo_pkg::*;
#(
  parameter int OVERCUR_CYC = OVERCUR_CYCLES,
  parameter int FB_PERIOD_CYC = FB_PERIOD_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [6:0] node_id,
  input wire logic nmt_operational,
  input wire logic rx_valid,
  input wire can_frame_t rx_frame,
  input wire sense_t sense,
  input wire logic inrush_phase,
  input wire logic tx_ready,
  output logic tx_valid,
  output can_frame_t tx_frame,
  output motion_cmd_t cmd,
  output logic motor_run,
  output logic brake_on
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [15:0] clamp_speed(input logic [15:0] s);
    if (s < SPEED_MIN) begin
      return SPEED_MIN;
    end else if (s > SPEED_MAX) begin
      return SPEED_MAX;
    end
    return s;
  endfunction

  function automatic motion_cmd_t decode_cmd(input logic [63:0] d);
    motion_cmd_t c;
    c.target_pos = d[CTL_POS_LO +: 16];
    c.current_limit = d[CTL_CUR_LO +: 16];
    c.speed = clamp_speed(d[CTL_SPD_LO +: 16]);
    // Profile approach modes
    // Unknown codes fall back to normal so the drive never sees them
    c.profile = (d[CTL_PROF_LO +: 8] > PROFILE_SMALL_STEP) ?
      PROFILE_NORMAL : d[CTL_PROF_LO +: 8];
    c.control_bits = d[CTL_BITS_LO +: 8];
    return c;
  endfunction

  function automatic logic [10:0] node_cob(input logic [10:0] base,
                                           input logic [6:0] nid);
    return base + {4'h0, nid};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Control path

  motion_cmd_t cmd_ff;
  motion_cmd_t nxt_cmd;
  logic run_ff;
  logic nxt_run;
  logic tripped_ff;
  logic nxt_tripped;
  logic rx_hit;
  logic trip;
  logic over_limit;

  assign rx_hit = rx_valid && nmt_operational &&
                  (rx_frame.id == node_cob(RPDO_BASE_ID, node_id));

  assign over_limit = run_ff && !inrush_phase &&
                      (sense.current > cmd_ff.current_limit);

  overcurrent_monitor #(
    .LIMIT_CYC(OVERCUR_CYC)
  ) u_overcurrent_monitor (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .over_limit(over_limit),
    .trip(trip)
  );

  always_comb begin
    nxt_cmd = cmd_ff;
    if (rx_hit) begin
      nxt_cmd = decode_cmd(rx_frame.data);
    end
    // Latch trip, set wins
    // A trip holds until the master sends a frame with enable clear
    nxt_tripped = trip ||
      (tripped_ff && !(rx_hit && !rx_frame.data[CTL_BITS_LO + ENABLE_BIT]));
    nxt_run = nxt_cmd.control_bits[ENABLE_BIT] && !nxt_tripped;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cmd_ff <= '{control_bits: RST_CONTROL_BITS, profile: PROFILE_NORMAL,
                  speed: SPEED_MIN, current_limit: RST_CURRENT_LIMIT,
                  target_pos: RST_TARGET_POS};
      run_ff <= 1'b0;
      tripped_ff <= 1'b0;
    end else begin
      cmd_ff <= nxt_cmd;
      run_ff <= nxt_run;
      tripped_ff <= nxt_tripped;
    end
  end

  assign cmd = cmd_ff;
  assign motor_run = run_ff;
  assign brake_on = tripped_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Feedback framer

  tx_state_t tx_state_ff;
  tx_state_t nxt_tx_state;
  can_frame_t tx_frame_ff;
  can_frame_t nxt_tx_frame;
  logic [31:0] per_cnt_ff;
  logic [31:0] nxt_per_cnt;
  logic tick;
  logic [7:0] dir_flags;

  assign tick = (per_cnt_ff == 32'(FB_PERIOD_CYC - 1));

  assign dir_flags = {6'h00,
                      sense.retracting && !sense.extending,
                      sense.extending && !sense.retracting};

  always_comb begin
    nxt_per_cnt = tick ? 32'h0000_0000 : per_cnt_ff + 32'h0000_0001;
    nxt_tx_state = tx_state_ff;
    nxt_tx_frame = tx_frame_ff;
    unique case (tx_state_ff)
      TX_IDLE: begin
        // Feedback only in operational; a missed tick is skipped, not queued
        if (tick && nmt_operational) begin
          nxt_tx_state = TX_WAIT;
          nxt_tx_frame.id = node_cob(TPDO_BASE_ID, node_id);
          nxt_tx_frame.data = {sense.error_flags, dir_flags, sense.duty,
                               sense.current, sense.position};
        end
      end
      TX_WAIT: begin
        if (tx_ready) begin
          nxt_tx_state = TX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_state_ff <= TX_IDLE;
      tx_frame_ff <= '0;
      per_cnt_ff <= 32'h0000_0000;
    end else begin
      tx_state_ff <= nxt_tx_state;
      tx_frame_ff <= nxt_tx_frame;
      per_cnt_ff <= nxt_per_cnt;
    end
  end

  assign tx_valid = (tx_state_ff == TX_WAIT);
  assign tx_frame = tx_frame_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_run_needs_enable: assert property (
    motor_run |-> cmd.control_bits[ENABLE_BIT])
    else $error("motor runs with enable clear");

  a_store_no_start: assert property (
    rx_hit && !rx_frame.data[CTL_BITS_LO + ENABLE_BIT] |=>
      !motor_run && cmd.target_pos == $past(rx_frame.data[15:0]))
    else $error("parameters not stored or motor started");

  a_enable_starts: assert property (
    rx_hit && rx_frame.data[CTL_BITS_LO + ENABLE_BIT] && !tripped_ff &&
    !trip |=> motor_run &&
      cmd.speed == clamp_speed($past(rx_frame.data[47:32])))
    else $error("enable did not start motion");

  a_foreign_ignored: assert property (
    rx_valid && !rx_hit |=> cmd == $past(cmd))
    else $error("foreign or non-operational frame accepted");

  a_tx_identifier: assert property (
    $rose(tx_valid) |-> tx_frame.id == node_cob(TPDO_BASE_ID, $past(node_id)))
    else $error("feedback identifier wrong");

  a_fb_position: assert property (
    $rose(tx_valid) |-> tx_frame.data[15:0] == $past(sense.position))
    else $error("position not in bytes 0-1");

  a_fb_current: assert property (
    $rose(tx_valid) |-> tx_frame.data[31:16] == $past(sense.current))
    else $error("current not in bytes 2-3");

  a_fb_duty: assert property (
    $rose(tx_valid) |-> tx_frame.data[47:32] == $past(sense.duty) &&
      tx_frame.data[63:56] == $past(sense.error_flags))
    else $error("duty or error byte misplaced");

  a_flags_exclusive: assert property (
    tx_valid |-> tx_frame.data[55:50] == 6'h00 &&
      !(tx_frame.data[48] && tx_frame.data[49]))
    else $error("direction flags malformed");

  a_speed_clamped: assert property (
    cmd.speed >= SPEED_MIN && cmd.speed <= SPEED_MAX)
    else $error("speed outside range");

  a_trip_brakes: assert property (
    trip |=> !motor_run && brake_on)
    else $error("overcurrent did not stop motor");

  a_profile_legal: assert property (
    cmd.profile <= PROFILE_SMALL_STEP)
    else $error("illegal profile held");

  a_tx_holds: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
    else $error("feedback dropped before taken");

  c_store_then_run: cover property (
    rx_hit && !rx_frame.data[56] ##[1:20] rx_hit && rx_frame.data[56]);
  c_trip: cover property (trip ##1 brake_on);
  c_tx_done: cover property (tx_valid && tx_ready);

endmodule

// ---- verification/can_master_model.sv ----
`timescale 1ns/1ps
module can_master_model
  import actuator_pdo_pkg::*;
(
  input wire logic core_clk,
  output logic rx_valid,
  output can_frame_t rx_frame,
  input wire logic tx_valid,
  input wire can_frame_t tx_frame,
  output logic tx_ready
);
  int ready_wait = 0;
  int wait_cnt = 0;
  int n_got = 0;
  can_frame_t got;
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
    tx_ready = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // Control frame send
  // Payload inverted after the pulse so stale bytes never look valid
  task automatic send(input logic [10:0] id, input logic [63:0] d);
    @(posedge core_clk);
    rx_valid <= 1'b1;
    rx_frame <= {id, d};
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_frame <= ~{id, d};
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Feedback sink, stalls ready_wait + 1 cycles per frame
  always @(posedge core_clk) begin
    tx_ready <= 1'b0;
    if (tx_valid && tx_ready) begin
      got <= tx_frame;
      n_got <= n_got + 1;
      wait_cnt <= 0;
    end else if (tx_valid) begin
      if (wait_cnt >= ready_wait) tx_ready <= 1'b1;
      else wait_cnt <= wait_cnt + 1;
    end
  end
endmodule

// ---- verification/actuator_pdo_control_feedback_bench.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
  end \
end
module actuator_pdo_control_feedback_bench
  import actuator_pdo_pkg::*;
;
  localparam int OC = 20;
  localparam int FB = 16;
  logic core_clk, rst_n, nmt_operational, inrush_phase;
  logic [6:0] node_id;
  sense_t sense;
  logic rx_valid, tx_ready, tx_valid, motor_run, brake_on;
  can_frame_t rx_frame, tx_frame;
  motion_cmd_t cmd;
  int errors = 0;
  int n_tests = 0;
  actuator_pdo_control_feedback #(.OVERCUR_CYC(OC), .FB_PERIOD_CYC(FB))
    u_actuator_pdo_control_feedback (.core_clk(core_clk), .rst_n(rst_n),
    .node_id(node_id), .nmt_operational(nmt_operational),
    .rx_valid(rx_valid), .rx_frame(rx_frame), .sense(sense),
    .inrush_phase(inrush_phase), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_frame(tx_frame), .cmd(cmd), .motor_run(motor_run),
    .brake_on(brake_on));
  can_master_model u_can_master_model (.core_clk(core_clk),
    .rx_valid(rx_valid), .rx_frame(rx_frame), .tx_valid(tx_valid),
    .tx_frame(tx_frame), .tx_ready(tx_ready));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [63:0] ctl(input logic [15:0] p, c, s,
                                      input logic [7:0] pr, b);
    return {b, pr, s, c, p};
  endfunction
  task automatic send(input logic [63:0] d);
    u_can_master_model.send(11'h213, d);
    @(negedge core_clk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    `CHK("motor_run", 1'b0, motor_run)
    `CHK("brake_on", 1'b0, brake_on)
    `CHK("speed", 16'h00c8, cmd.speed)
    $display("test reset done");
  endtask
  task automatic t_store;
    send(ctl(16'h03e8, 16'h007d, 16'h0320, 8'h00, 8'h00));
    repeat (3) @(negedge core_clk);
    `CHK("target_pos", 16'h03e8, cmd.target_pos)
    `CHK("current_limit", 16'h007d, cmd.current_limit)
    `CHK("speed", 16'h0320, cmd.speed)
    `CHK("motor_run", 1'b0, motor_run)
    $display("test store done");
  endtask
  task automatic t_enable;
    send(ctl(16'h0100, 16'h007d, 16'h0320, 8'h00, 8'h01));
    `CHK("motor_run", 1'b1, motor_run)
    `CHK("target_pos", 16'h0100, cmd.target_pos)
    $display("test enable done");
  endtask
  task automatic t_refuse;
    u_can_master_model.send(11'h214, ctl(0, 0, 16'h0200, 0, 0));
    @(negedge core_clk);
    `CHK("wrong id run", 1'b1, motor_run)
    `CHK("wrong id speed", 16'h0320, cmd.speed)
    @(posedge core_clk) nmt_operational <= 1'b0;
    send(ctl(0, 0, 16'h0200, 0, 0));
    `CHK("preop run", 1'b1, motor_run)
    @(posedge core_clk) nmt_operational <= 1'b1;
    send(ctl(0, 0, 16'h0200, 0, 0));
    `CHK("disable", 1'b0, motor_run)
    $display("test refuse done");
  endtask
  task automatic t_range;
    logic [15:0] s_in[4] = '{16'h0064, 16'h00c8, 16'h03e8, 16'h0500};
    logic [15:0] s_ex[4] = '{16'h00c8, 16'h00c8, 16'h03e8, 16'h03e8};
    logic [7:0] p_ex[4] = '{8'h00, 8'h01, 8'h02, 8'h00};
    for (int i = 0; i < 4; i++) begin
      send(ctl(0, 0, s_in[i], 8'(i), 0));
      `CHK("speed", s_ex[i], cmd.speed)
      `CHK("profile", p_ex[i], cmd.profile)
    end
    $display("test range done");
  endtask
  task automatic t_feedback;
    logic [7:0] fl[3] = '{8'h01, 8'h02, 8'h00};
    int n0, k;
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      sense <= '{16'h1234 + 16'(i), 16'h0056, 16'h0320,
                 i != 1, i != 0, 8'ha5};
      u_can_master_model.ready_wait = i + 1;
      n0 = u_can_master_model.n_got;
      k = 0;
      while (u_can_master_model.n_got < n0 + 2 && k < 200) begin
        @(negedge core_clk);
        k++;
      end
      `CHK("id", 11'h193, u_can_master_model.got.id)
      `CHK("pos", 16'h1234 + 16'(i), u_can_master_model.got.data[15:0])
      `CHK("cur", 16'h0056, u_can_master_model.got.data[31:16])
      `CHK("duty", 16'h0320, u_can_master_model.got.data[47:32])
      `CHK("flags", fl[i], u_can_master_model.got.data[55:48])
      `CHK("err", 8'ha5, u_can_master_model.got.data[63:56])
      `CHK("tx_valid low", 1'b0, tx_valid)
    end
    $display("test feedback done");
  endtask
  task automatic t_overcur;
    int k;
    @(posedge core_clk) begin
      sense.current <= 16'h0005;
      inrush_phase <= 1'b1;
    end
    send(ctl(0, 16'h0010, 16'h0320, 0, 1));
    @(posedge core_clk) sense.current <= 16'h0020;
    // Inrush window must not count toward the trip
    repeat (3 * OC) @(negedge core_clk);
    `CHK("inrush brake", 1'b0, brake_on)
    @(posedge core_clk) inrush_phase <= 1'b0;
    k = 0;
    while (brake_on !== 1'b1 && k < 3 * OC) begin
      @(negedge core_clk);
      k++;
    end
    `CHK("trip not early", 1'b1, k > OC)
    `CHK("trip not late", 1'b1, k <= OC + 4)
    `CHK("stopped", 1'b0, motor_run)
    @(posedge core_clk) sense.current <= 16'h0005;
    send(ctl(0, 16'h0010, 16'h0320, 0, 0));
    `CHK("brake clear", 1'b0, brake_on)
    $display("test overcurrent done");
  endtask
  // Mid-run reset while running must drop motion and stored values
  task automatic t_rerun;
    send(ctl(16'h0077, 16'h007d, 16'h0320, 8'h01, 8'h01));
    @(posedge core_clk) rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    `CHK("rerun run", 1'b0, motor_run)
    `CHK("rerun pos", 16'h0000, cmd.target_pos)
    `CHK("rerun tx_valid", 1'b0, tx_valid)
    send(ctl(16'h0077, 16'h007d, 16'h0320, 8'h01, 8'h01));
    `CHK("rerun start", 1'b1, motor_run)
    `CHK("rerun target", 16'h0077, cmd.target_pos)
    send(ctl(0, 16'h007d, 16'h0320, 0, 0));
    $display("test rerun done");
  endtask
  task automatic t_node;
    int n0, k;
    @(posedge core_clk) node_id <= 7'h05;
    u_can_master_model.send(11'h205, ctl(16'h0042, 0, 16'h0320, 0, 0));
    @(negedge core_clk);
    `CHK("node pos", 16'h0042, cmd.target_pos)
    n0 = u_can_master_model.n_got;
    k = 0;
    while (u_can_master_model.n_got < n0 + 2 && k < 200) begin
      @(negedge core_clk);
      k++;
    end
    `CHK("node id", 11'h185, u_can_master_model.got.id)
    @(posedge core_clk) node_id <= 7'h13;
    $display("test node done");
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    node_id = 7'h13;
    nmt_operational = 1'b1;
    inrush_phase = 1'b0;
    sense = '0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    t_reset();
    t_store();
    t_enable();
    t_refuse();
    t_range();
    t_feedback();
    t_overcur();
    t_rerun();
    t_node();
    conclude();
  end
  // Whole run is a few hundred cycles; this leaves wide margin
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    conclude();
  end
endmodule
